/* rtl/bcie_defs.svh */
`ifndef BCIE_DEFS_SVH
`define BCIE_DEFS_SVH
// Register byte addresses; the condition register keeps its index.
`define BCIE_ADDR_FLAGS   8'h00
`define BCIE_ADDR_ENABLE  8'h04
`define BCIE_ADDR_CONFIG  8'h08
`define BCIE_COND_IDX     8'h37
`define BCIE_ADDR_COND    8'hdc
// Flag register bit positions.
`define BCIE_B_FRAME      15
`define BCIE_B_SELECTED_MESSAGE_FLAG     14
`define BCIE_B_QWRAP      13
`define BCIE_B_RETRY      12
`define BCIE_B_NEST       11
`define BCIE_B_TRAP       10
`define BCIE_B_STAT       9
`define BCIE_B_MERR       4
`define BCIE_B_DONE       3
`define BCIE_B_URQ_LO     5
`define BCIE_B_URQ_HI     8
// Writable flag and enable bits; bits 2-0 stay zero.
`define BCIE_FLAG_MASK    16'hfff8
// Configuration bits.
`define BCIE_CFG_RETRY    0
`define BCIE_CFG_BCRMASK  1
`define BCIE_CFG_GAPCHK   2
`define BCIE_CFG_FMTCHK   13
// Condition register run bit.
`define BCIE_COND_RUN     15
// Control word bits.
`define BCIE_CW_EOMSEL    4
`define BCIE_CW_RTRT      1
`define BCIE_CW_MASKBCR   9
// Status word fields and the eight checked bits.
`define BCIE_SW_ADDR_HI   15
`define BCIE_SW_ADDR_LO   11
`define BCIE_SW_ME        10
`define BCIE_SW_BCR       4
`define BCIE_SW_CHECKED   11'h71f
// Expected value of instruction bits 9-5.
`define BCIE_INSTR_FIELD  5'h00
// Nesting level limits and queue depth.
`define BCIE_NEST_MAX     3'h7
`define BCIE_NEST_MIN     3'h0
`define BCIE_QUEUE_LAST   6'h3f
// Reset values.
`define BCIE_RST_ENABLE   16'h0000
`define BCIE_RST_CONFIG   16'h0000
`endif

/* rtl/bcie_pkg.sv */
package bcie_pkg;
  // Register word as seen on the bus.
  typedef logic [31:0] bcie_word_t;
  // Sixteen-bit register contents.
  typedef logic [15:0] bcie_reg_t;
  // Sequencer run state.
  typedef enum logic [1:0] {
    BCIE_STOP     = 2'b00,
    BCIE_RUN      = 2'b01,
    BCIE_HALT_PND = 2'b10
  } bcie_run_e;
endpackage : bcie_pkg

/* rtl/bcie_nest_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries call and return strobes to the nesting counter and its answers.
interface bcie_nest_if;
  logic       call_exec;  // Call instruction executed.
  logic       ret_exec;   // Return instruction executed.
  logic [2:0] level;      // Current nesting level.
  logic       overflow;   // Call seen at the top level.
  logic       underflow;  // Return seen at level zero.
  modport ctr (input call_exec, ret_exec,
               output level, overflow, underflow);
  modport usr (output call_exec, ret_exec,
               input level, overflow, underflow);
endinterface : bcie_nest_if
`default_nettype wire

/* rtl/bcie_nest.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bcie_defs.svh"
// Subroutine nesting counter with overflow and underflow detection.
module bcie_nest (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST,
  // Strobes and answers.
  bcie_nest_if.ctr nest
);
  import bcie_pkg::*;

  logic [2:0] level_r;    // Current level.
  logic [2:0] level_nxt;  // Next level.
  logic       at_top;     // Level already at the limit.
  logic       at_bot;     // Level at zero.

  assign at_top = (level_r == `BCIE_NEST_MAX);
  assign at_bot = (level_r == `BCIE_NEST_MIN);
  // The level saturates, so an error never wraps it around.
  assign level_nxt = (nest.call_exec && !at_top) ? level_r + 3'h1 :
                     (nest.ret_exec && !at_bot)  ? level_r - 3'h1 :
                     level_r;
  assign nest.overflow  = nest.call_exec && at_top;
  assign nest.underflow = nest.ret_exec && at_bot;
  assign nest.level     = level_r;

  // Level register.
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      level_r <= 3'h0;
    end
    else
    begin
      level_r <= level_nxt;
    end
  end
endmodule : bcie_nest
`default_nettype wire

/* rtl/bcie_top.sv */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bcie_defs.svh"
// Event flags of the bus controller interrupt register with an APB slave.
module bcie_top (
  // Clock and reset.
  input  wire logic                MCLK,
  input  wire logic                RST,
  // APB slave port.
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output var  bcie_pkg::bcie_word_t PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // Sequencer instruction events.
  input  wire logic                FETCH_VALID,
  input  wire logic                FETCH_UNDEF,
  input  wire logic                FETCH_PAR_ERR,
  input  wire logic [4:0]          FETCH_FIELD,
  input  wire logic                CALL_EXEC,
  input  wire logic                RET_EXEC,
  input  wire logic                IRQ_EXEC,
  input  wire logic [15:0]         IRQ_PARAM,
  // Message events.
  input  wire logic                MSG_ACTIVE,
  input  wire logic                MSG_DONE,
  input  wire logic [15:0]         MSG_CTRL,
  input  wire logic                MSG_RETRIED,
  input  wire logic                CMD_FMT_VALID,
  input  wire logic [2:0]          CMD_FMT,
  input  wire logic                STAT_VALID,
  input  wire logic [15:0]         STAT_WORD,
  input  wire logic [4:0]          EXP_ADDR,
  input  wire logic                BCAST_MSG,
  input  wire logic                RESP_TIMEOUT,
  input  wire logic                LOOP_FAIL,
  input  wire logic                GAP_VIOL,
  input  wire logic                QUEUE_STEP,
  input  wire logic                FRAME_EXPIRE,
  // Sequencer control outputs.
  output logic                     SEQ_RUN,
  output logic                     TX_STORED_CMD,
  output logic                     BLOCK_16WORD,
  output logic [2:0]               NEST_LEVEL
);
  import bcie_pkg::*;

  // Registers.
  bcie_reg_t  flags_r;       // Latched event flags.
  bcie_reg_t  flags_nxt;     // Next flag value.
  bcie_reg_t  enable_r;      // Event enables.
  bcie_reg_t  config_r;      // Configuration bits.
  bcie_run_e  run_r;         // Sequencer run state.
  bcie_run_e  run_nxt;       // Next run state.
  logic [5:0] qptr_r;        // Queue pointer offset from the base.
  logic       tx_stored_r;   // Stored command words are sent.
  logic       blk16_r;       // Message block is 16 words long.
  bcie_word_t prdata_r;      // Read data register.
  logic       pslverr_r;     // Error answer register.

  // Bus decode.
  logic       setup_ph;      // Setup phase of a transfer.
  logic       wr_acc;        // Write access completes.
  logic       hit_flags;     // Flag register addressed.
  logic       hit_enable;    // Enable register addressed.
  logic       hit_config;    // Configuration register addressed.
  logic       hit_cond;      // Condition register addressed.
  logic       hit_any;       // Any mapped register addressed.
  bcie_reg_t  wdata;         // Low half of the write data.
  bcie_reg_t  rd_mux;        // Selected read value.
  bcie_reg_t  cond_view;     // Condition register as read.
  bcie_reg_t  clr_mask;      // Flags cleared by this write.

  // Event decode.
  bcie_reg_t  set_raw;       // Events seen this cycle.
  bcie_reg_t  set_vec;       // Events gated by their enables.
  logic       illegal;       // Fetched instruction is illegal.
  logic       fmt_check;     // Format check is active.
  logic       fmt_mis;       // Control and command formats differ.
  logic       stat_addr_bad; // Status address is wrong.
  logic       stat_bits_bad; // A checked status bit is unexpected.
  logic       exp_bcr;       // Expected broadcast-received value.
  logic [10:0] stat_exp;     // Expected values of status bits 10-0.
  logic       merr_ev;       // Any message error cause.
  logic       qwrap;         // Queue pointer rolls over.
  logic       urq_load;      // User request code loads.

  // Nesting counter carrier.
  bcie_nest_if nest_bus ();

  bcie_nest u_nest (
    .MCLK (MCLK),
    .RST  (RST),
    .nest (nest_bus)
  );

  // Executed call and return strobes go straight to the counter; a call
  // and a return in the same cycle count as a call below level 7 and as a return at level 7.
  assign nest_bus.call_exec = CALL_EXEC;
  assign nest_bus.ret_exec  = RET_EXEC;

  // APB decode: every access finishes in its first access cycle.
  // Writes land at the access edge; reads were captured at setup.
  assign setup_ph   = PSEL && !PENABLE;
  assign wr_acc     = PSEL && PENABLE && PWRITE;
  assign hit_flags  = (PADDR == `BCIE_ADDR_FLAGS);
  assign hit_enable = (PADDR == `BCIE_ADDR_ENABLE);
  assign hit_config = (PADDR == `BCIE_ADDR_CONFIG);
  assign hit_cond   = (PADDR == `BCIE_ADDR_COND);
  assign hit_any    = hit_flags || hit_enable || hit_config || hit_cond;
  assign wdata      = PWDATA[15:0];

  // Flags are cleared by writing ones; bits 2-0 never store.
  // A zero written to a flag bit leaves that flag as it is.
  assign clr_mask = (wr_acc && hit_flags) ?
                    (wdata & `BCIE_FLAG_MASK) : 16'h0000;

  // The condition register shows the run bit and nesting level.
  // Bits 14-3 read zero, and the level field cannot be written.
  assign cond_view = {(run_r != BCIE_STOP), 12'h000,
                      nest_bus.level};

  // Read selection; unmapped addresses read zero.
  // Reserved flag bits are masked again so they never read one.
  assign rd_mux = hit_flags  ? (flags_r & `BCIE_FLAG_MASK) :
                  hit_enable ? enable_r :
                  hit_config ? config_r :
                  hit_cond   ? cond_view :
                  16'h0000;

  // An instruction is illegal when undefined, bad parity or bad field.
  // Only a fetch qualifies the three checks; idle cycles are never illegal.
  assign illegal = FETCH_VALID &&
                   (FETCH_UNDEF || FETCH_PAR_ERR ||
                    (FETCH_FIELD != `BCIE_INSTR_FIELD));

  // Format check compares control word bits 2-0 to the commands.
  // The comparison only counts while the decoded format is valid.
  assign fmt_check = config_r[`BCIE_CFG_FMTCHK];
  assign fmt_mis   = fmt_check && CMD_FMT_VALID &&
                     (MSG_CTRL[2:0] != CMD_FMT);

  // Expected BCR comes from the control word unless masking is on.
  // With masking on, a set BCR bit in the status is unexpected.
  assign exp_bcr = config_r[`BCIE_CFG_BCRMASK] ? 1'b0 :
                   MSG_CTRL[`BCIE_CW_MASKBCR];

  // Every other checked bit is expected to be zero.
  assign stat_exp = {6'h00, exp_bcr, 4'h0};

  // A wrong address field sets the status and message error flags.
  assign stat_addr_bad = STAT_VALID &&
    (STAT_WORD[`BCIE_SW_ADDR_HI:`BCIE_SW_ADDR_LO] != EXP_ADDR);
  // Reserved status bits 7-5 are left out of the comparison.
  assign stat_bits_bad = STAT_VALID &&
    (((STAT_WORD[10:0] ^ stat_exp) & `BCIE_SW_CHECKED) != 11'h000);

  // Message error causes, gap check only when configured.
  // A broadcast message ignores the ME bit of any status seen.
  assign merr_ev =
    (STAT_VALID && STAT_WORD[`BCIE_SW_ME] && !BCAST_MSG) ||
    RESP_TIMEOUT || LOOP_FAIL || stat_addr_bad ||
    (GAP_VIOL && config_r[`BCIE_CFG_GAPCHK]);

  // The pointer wraps when it steps past its last queue word.
  // Sixty-four steps from the base bring the pointer back to it.
  assign qwrap = QUEUE_STEP && (qptr_r == `BCIE_QUEUE_LAST);

  // A request instruction loads the user code when enabled.
  // The code field has one enable, the lowest of its four bits.
  assign urq_load = IRQ_EXEC && enable_r[`BCIE_B_URQ_LO];

  // Collect single-bit events into their flag positions.
  // Bits 8-5 load separately, and bits 2-0 never set.
  always_comb
  begin
    set_raw = 16'h0000;
    set_raw[`BCIE_B_FRAME]  = FRAME_EXPIRE;
    set_raw[`BCIE_B_SELECTED_MESSAGE_FLAG] = MSG_DONE &&
                              MSG_CTRL[`BCIE_CW_EOMSEL];
    set_raw[`BCIE_B_QWRAP]  = qwrap;
    set_raw[`BCIE_B_RETRY]  = MSG_DONE && MSG_RETRIED &&
                              config_r[`BCIE_CFG_RETRY];
    set_raw[`BCIE_B_NEST]   = nest_bus.overflow ||
                              nest_bus.underflow;
    set_raw[`BCIE_B_TRAP]   = illegal || fmt_mis;
    set_raw[`BCIE_B_STAT]   = stat_addr_bad || stat_bits_bad;
    set_raw[`BCIE_B_MERR]   = merr_ev;
    set_raw[`BCIE_B_DONE]   = MSG_DONE;
  end

  // Only enabled events set a flag.
  // The reserved bits are masked again so no enable reaches them.
  assign set_vec = set_raw & enable_r & `BCIE_FLAG_MASK;

  // Flag update: a set in the clearing cycle wins over the clear.
  // So an event that meets a clear is never lost.
  always_comb
  begin
    flags_nxt = (flags_r & ~clr_mask) | set_vec;
    if (urq_load)
    begin
      // The code field takes the four low parameter bits.
      flags_nxt[`BCIE_B_URQ_HI:`BCIE_B_URQ_LO] = IRQ_PARAM[3:0];
    end
    flags_nxt[2:0] = 3'b000;
  end

  // Run state: illegal instructions halt after the current message.
  // Software may start or stop it; a pending halt ignores writes.
  always_comb
  begin
    run_nxt = run_r;
    case (run_r)
      BCIE_STOP:
      begin
        // Software starts the sequencer by writing the run bit.
        if (wr_acc && hit_cond && wdata[`BCIE_COND_RUN])
        begin
          run_nxt = BCIE_RUN;
        end
      end
      BCIE_RUN:
      begin
        // A format trap alone leaves the sequencer running.
        if (illegal)
        begin
          run_nxt = BCIE_HALT_PND;
        end
        else if (wr_acc && hit_cond && !wdata[`BCIE_COND_RUN])
        begin
          run_nxt = BCIE_STOP;
        end
        else
        begin
          run_nxt = BCIE_RUN;
        end
      end
      BCIE_HALT_PND:
      begin
        // Stop once no message is in flight.
        if (!MSG_ACTIVE)
        begin
          run_nxt = BCIE_STOP;
        end
      end
      default:
      begin
        run_nxt = BCIE_STOP;
      end
    endcase
  end

  // Flag, enable and configuration registers.
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      flags_r  <= 16'h0000;
      enable_r <= `BCIE_RST_ENABLE;
      config_r <= `BCIE_RST_CONFIG;
    end
    else
    begin
      flags_r <= flags_nxt;
      if (wr_acc && hit_enable)
      begin
        enable_r <= wdata & `BCIE_FLAG_MASK;
      end
      if (wr_acc && hit_config)
      begin
        config_r <= wdata;
      end
    end
  end

  // Run state and queue pointer.
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      run_r  <= BCIE_STOP;
      qptr_r <= 6'h00;
    end
    else
    begin
      run_r <= run_nxt;
      if (QUEUE_STEP)
      begin
        qptr_r <= qwrap ? 6'h00 : qptr_r + 6'h01;
      end
    end
  end

  // Message block handling after a format comparison.
  // Between formats the block length keeps its last value.
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      tx_stored_r <= 1'b1;
      blk16_r     <= 1'b0;
    end
    else if (CMD_FMT_VALID)
    begin
      // Stored command words are always what goes on the bus.
      tx_stored_r <= 1'b1;
      // The control word's RT-to-RT bit sets the block length.
      blk16_r <= MSG_CTRL[`BCIE_CW_RTRT];
    end
  end

  // Read data and error answer are captured in the setup phase.
  // A read returns the value that stood in its setup cycle.
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r  <= {16'h0000, rd_mux};
      pslverr_r <= !hit_any;
    end
  end

  // Outputs.
  assign PRDATA        = prdata_r;
  // The slave never inserts a wait state.
  assign PREADY        = 1'b1;
  assign PSLVERR       = pslverr_r && PSEL && PENABLE;
  // Sequencer state and message block handling.
  assign SEQ_RUN       = (run_r != BCIE_STOP);
  assign TX_STORED_CMD = tx_stored_r;
  assign BLOCK_16WORD  = blk16_r;
  assign NEST_LEVEL    = nest_bus.level;
endmodule : bcie_top
`default_nettype wire

/* sim/bcie_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Checks the sequencer outputs and bus timing of the event flag block.
module bcie_top_props (
  // Clock and reset.
  input wire logic        MCLK,
  input wire logic        RST,
  // APB handshake.
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic        PSLVERR,
  // Events and outputs.
  input wire logic        FETCH_VALID,
  input wire logic        FETCH_UNDEF,
  input wire logic        CALL_EXEC,
  input wire logic        RET_EXEC,
  input wire logic        MSG_ACTIVE,
  input wire logic [15:0] MSG_CTRL,
  input wire logic        CMD_FMT_VALID,
  input wire logic        SEQ_RUN,
  input wire logic        TX_STORED_CMD,
  input wire logic        BLOCK_16WORD,
  input wire logic [2:0]  NEST_LEVEL
);
  // All checks sample on the one clock and rest during reset.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  nest_up_a: assert property (
    CALL_EXEC && !RET_EXEC && NEST_LEVEL != 3'h7
    |=> NEST_LEVEL == $past(NEST_LEVEL) + 3'h1)
    else $error("nesting level did not rise");
  nest_down_a: assert property (
    RET_EXEC && !CALL_EXEC && NEST_LEVEL != 3'h0
    |=> NEST_LEVEL == $past(NEST_LEVEL) - 3'h1)
    else $error("nesting level did not fall");
  nest_top_a: assert property (
    CALL_EXEC && !RET_EXEC && NEST_LEVEL == 3'h7 |=> NEST_LEVEL == 3'h7)
    else $error("nesting level left the top");
  nest_floor_a: assert property (
    RET_EXEC && !CALL_EXEC && NEST_LEVEL == 3'h0 |=> NEST_LEVEL == 3'h0)
    else $error("nesting level left zero");
  halt_after_a: assert property (
    SEQ_RUN && FETCH_VALID && FETCH_UNDEF ##1 !MSG_ACTIVE && !PSEL
    |=> !SEQ_RUN)
    else $error("sequencer kept running after illegal fetch");
  run_hold_a: assert property (
    SEQ_RUN && MSG_ACTIVE && !(PSEL && PWRITE) |=> SEQ_RUN)
    else $error("sequencer stopped during a message");
  stored_cmd_a: assert property (
    TX_STORED_CMD)
    else $error("stored command words not selected");
  block_len_a: assert property (
    CMD_FMT_VALID |=> BLOCK_16WORD == $past(MSG_CTRL[1]))
    else $error("block length does not follow control word");
  err_phase_a: assert property (
    PSLVERR |-> PSEL && PENABLE)
    else $error("bus error outside access phase");
  // Main scenarios that the bench must reach.
  cover property (CALL_EXEC && NEST_LEVEL == 3'h7);
  cover property (RET_EXEC && NEST_LEVEL == 3'h0);
  cover property (SEQ_RUN && FETCH_VALID && FETCH_UNDEF);
endmodule : bcie_top_props
bind bcie_top bcie_top_props u_bcie_top_props (
  .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PSLVERR(PSLVERR), .FETCH_VALID(FETCH_VALID),
  .FETCH_UNDEF(FETCH_UNDEF), .CALL_EXEC(CALL_EXEC), .RET_EXEC(RET_EXEC),
  .MSG_ACTIVE(MSG_ACTIVE), .MSG_CTRL(MSG_CTRL),
  .CMD_FMT_VALID(CMD_FMT_VALID), .SEQ_RUN(SEQ_RUN),
  .TX_STORED_CMD(TX_STORED_CMD), .BLOCK_16WORD(BLOCK_16WORD),
  .NEST_LEVEL(NEST_LEVEL));
`default_nettype wire

/* sim/bcie_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bcie_defs.svh"
// Self-checking bench for the event flag block.
module bcie_top_test;
  import bcie_pkg::*;
  logic        mclk;             // Bench clock.
  logic        rst = 1'b1;       // Synchronous reset.
  logic        psel = 1'b0;      // Bus select.
  logic        penable = 1'b0;   // Bus access phase.
  logic        pwrite = 1'b0;    // Bus direction.
  logic [7:0]  paddr = 8'h00;    // Bus address.
  logic [31:0] pwdata = 32'h0;   // Bus write data.
  bcie_word_t  prdata;           // Bus read data.
  logic        pready, pslverr;  // Bus answer.
  logic [11:0] ev = 12'h000;     // One pulse line per event input.
  logic        undef = 1'b0, par = 1'b0, mact = 1'b0, retried = 1'b0;
  logic [4:0]  field = 5'h00, eaddr = 5'h00;
  logic [15:0] param = 16'h0, ctrl = 16'h0, stat = 16'h0;
  logic [2:0]  fmt = 3'h0;
  logic        bcast = 1'b0;     // Broadcast message level.
  logic        seq_run, tx_cmd, blk16;
  logic [2:0]  nest;
  logic [32:0] exp_q[$];         // Noted read results, oldest first.
  int          bad_count = 0, samples_checked = 0, seed, r;

  bcie_top u_bcie_top (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FETCH_VALID(ev[0]),
    .FETCH_UNDEF(undef), .FETCH_PAR_ERR(par), .FETCH_FIELD(field),
    .CALL_EXEC(ev[1]), .RET_EXEC(ev[2]), .IRQ_EXEC(ev[3]),
    .IRQ_PARAM(param), .MSG_ACTIVE(mact), .MSG_DONE(ev[4]),
    .MSG_CTRL(ctrl), .MSG_RETRIED(retried), .CMD_FMT_VALID(ev[5]),
    .CMD_FMT(fmt), .STAT_VALID(ev[6]), .STAT_WORD(stat),
    .EXP_ADDR(eaddr), .BCAST_MSG(bcast), .RESP_TIMEOUT(ev[7]),
    .LOOP_FAIL(ev[8]), .GAP_VIOL(ev[9]), .QUEUE_STEP(ev[10]),
    .FRAME_EXPIRE(ev[11]), .SEQ_RUN(seq_run), .TX_STORED_CMD(tx_cmd),
    .BLOCK_16WORD(blk16), .NEST_LEVEL(nest));

  // Free-running 20 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Counts one comparison and reports it when the values differ.
  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // One bus transfer: setup, then access held until ready is seen.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      bad_count++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Notes the expected read result, then reads.
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Pulses one event input for a single cycle.
  task automatic fire(input int b);
    @(posedge mclk);
    ev <= 12'h001 << b;
    @(posedge mclk);
    ev <= 12'h000;
  endtask : fire

  // Clears all flags, raises one event and reads the flags back.
  task automatic ev_case(input int b, input logic [15:0] e);
    apb(1'b1, `BCIE_ADDR_FLAGS, 32'hffff);
    fire(b);
    rd(`BCIE_ADDR_FLAGS, {17'h0, e});
  endtask : ev_case

  // Compares each completed read with the oldest noted result.
  always @(posedge mclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("read data", {pslverr, prdata}, exp_q.pop_front());

  // Cuts a hang short.
  initial
  begin
    #2000000;
    bad_count++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    seed = 32'ha8fa;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(`BCIE_ADDR_ENABLE, 33'h0);
    rd(`BCIE_ADDR_COND, 33'h0);
    rd(8'h10, {1'b1, 32'h0});
    apb(1'b1, 8'h10, $random(seed));
    check("stored commands", {32'h0, tx_cmd}, 33'h1);
    ev_case(4, 16'h0000);
    apb(1'b1, `BCIE_ADDR_ENABLE, 32'hffff);
    rd(`BCIE_ADDR_ENABLE, 33'hfff8);
    ev_case(11, 16'h8000);
    apb(1'b1, `BCIE_ADDR_FLAGS, 32'h0007);
    rd(`BCIE_ADDR_FLAGS, 33'h8000);
    apb(1'b1, `BCIE_ADDR_CONFIG, 32'h2005);
    $display("test registers done");
    ctrl <= 16'h0010;
    ev_case(4, 16'h4008);
    ctrl <= 16'h0000;
    retried <= 1'b1;
    ev_case(4, 16'h1008);
    retried <= 1'b0;
    for (int b = 7; b <= 9; b++)
      ev_case(b, 16'h0010);
    eaddr <= 5'h05;
    stat <= 16'h3000;
    ev_case(6, 16'h0210);
    stat <= 16'h2801;
    ev_case(6, 16'h0200);
    stat <= 16'h2810;
    ev_case(6, 16'h0200);
    ctrl <= 16'h0200;
    ev_case(6, 16'h0000);
    apb(1'b1, `BCIE_ADDR_CONFIG, 32'h2007);
    stat <= 16'h2800;
    ev_case(6, 16'h0000);
    apb(1'b1, `BCIE_ADDR_CONFIG, 32'h2005);
    ctrl <= 16'h0000;
    stat <= 16'h2900;
    ev_case(6, 16'h0200);
    stat <= 16'h2c00;
    ev_case(6, 16'h0210);
    bcast <= 1'b1;
    ev_case(6, 16'h0200);
    bcast <= 1'b0;
    r = $random(seed);
    param <= r[15:0];
    ev_case(3, {7'h0, r[3:0], 5'h0});
    par <= 1'b1;
    ev_case(0, 16'h0400);
    par <= 1'b0;
    field <= 5'h01;
    ev_case(0, 16'h0400);
    field <= 5'h00;
    $display("test events done");
    apb(1'b1, `BCIE_ADDR_COND, 32'h8000);
    mact <= 1'b1;
    ctrl <= 16'h0002;
    ev_case(5, 16'h0400);
    check("block length", {32'h0, blk16}, 33'h1);
    rd(`BCIE_ADDR_COND, 33'h8000);
    check("sequencer run", {32'h0, seq_run}, 33'h1);
    fmt <= 3'h2;
    ev_case(5, 16'h0000);
    apb(1'b1, `BCIE_ADDR_CONFIG, 32'h0005);
    fmt <= 3'h0;
    ev_case(5, 16'h0000);
    undef <= 1'b1;
    ev_case(0, 16'h0400);
    rd(`BCIE_ADDR_COND, 33'h8000);
    mact <= 1'b0;
    rd(`BCIE_ADDR_COND, 33'h0);
    check("sequencer run", {32'h0, seq_run}, 33'h0);
    apb(1'b1, `BCIE_ADDR_COND, 32'h8000);
    fire(0);
    rd(`BCIE_ADDR_COND, 33'h0);
    undef <= 1'b0;
    $display("test sequencer done");
    ev_case(2, 16'h0800);
    repeat (7) fire(1);
    rd(`BCIE_ADDR_COND, 33'h7);
    ev_case(1, 16'h0800);
    check("nesting level", {30'h0, nest}, 33'h7);
    repeat (3) fire(2);
    rd(`BCIE_ADDR_COND, 33'h4);
    $display("test nesting done");
    apb(1'b1, `BCIE_ADDR_FLAGS, 32'hffff);
    repeat (63) fire(10);
    rd(`BCIE_ADDR_FLAGS, 33'h0);
    fire(10);
    rd(`BCIE_ADDR_FLAGS, 33'h2000);
    rd(`BCIE_ADDR_FLAGS, 33'h2000);
    $display("test queue done");
    repeat (2) @(posedge mclk);
    end_of_test();
  end
endmodule : bcie_top_test
`default_nettype wire
